// ==== rtl/adc_sar_control_regs.sv ====
// Local design decision: the APB slave port.
`timescale 1ns/1ps
module adc_sar_control_regs
  import adc_ctrl_pkg::*;
#(
  parameter int NUM_CHANNELS = 8
) (
  input  wire logic        clk,          // 100 MHz clock
  input  wire logic        resetn,       // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB direction
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  input  wire logic        comp_in,      // Comparator: input above trial
  output afe_cmd_t         afe_cmd,      // Analog front-end control
  output logic             afe_power     // Converter bias enable
);

  // Bus state
  logic [31:0] prdata_r, prdata_nxt;
  logic        pready_r, pready_nxt;
  logic        pslverr_r, pslverr_nxt;
  // Register state
  logic        power_r, power_nxt;
  logic [2:0]  chan_r, chan_nxt;
  logic        done_r, done_nxt;
  logic [7:0]  result_r, result_nxt;
  // Sequencer state
  conv_state_t state_r, state_nxt;
  logic [5:0]  cnt_r, cnt_nxt;
  logic [7:0]  sar_r, sar_nxt;
  logic [2:0]  bit_r, bit_nxt;
  afe_cmd_t    afe_r, afe_nxt;
  // Comparator synchroniser
  logic        comp_s1_r, comp_s1_nxt;
  logic        comp_s2_r, comp_s2_nxt;

  logic        acc, wr_ctrl, rd_result, hit_ctrl, hit_result;

  // Word address decode: index times four
  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] idx);
    return a == 12'((idx << 2));
  endfunction

  // Channels beyond the variant's count fold to input 0
  // Limitation: software cannot tell that a folded code converted input 0
  function automatic logic [2:0] chan_decode(input logic [2:0] c);
    return (int'(c) < NUM_CHANNELS) ? c : 3'h0;
  endfunction

  // A transfer completes at the access edge where pready_r is high; writes
  // and the read side effect on the done flag act only at that edge
  assign acc        = psel && penable && pready_r;
  assign hit_ctrl   = addr_is(paddr, CTRL_IDX);
  assign hit_result = addr_is(paddr, RESULT_IDX);
  assign wr_ctrl    = acc && pwrite && hit_ctrl;
  assign rd_result  = acc && !pwrite && hit_result;

  // Outputs straight from flops
  assign prdata    = prdata_r;
  assign pready    = pready_r;
  assign pslverr   = pslverr_r;
  assign afe_cmd   = afe_r;
  assign afe_power = power_r;

  // Read data is captured in the setup cycle, so a flag that sets during
  // the access cycle shows on the next read instead
  // APB slave: no wait states, read data sampled at the setup cycle
  always_comb begin
    prdata_nxt  = 32'h0000_0000;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    if (psel && !penable) begin
      pready_nxt  = 1'b1;
      pslverr_nxt = !(hit_ctrl || hit_result);
      if (!pwrite && hit_result) begin
        prdata_nxt = {24'h00_0000, result_r};
      end else if (!pwrite && hit_ctrl) begin
        // Bits 6,4,3 read zero; bit 4 is forced
        prdata_nxt = {24'h00_0000, done_r, 1'b0, power_r, 2'b00, chan_r};
      end
    end else if (psel && penable && !pready_r) begin
      pready_nxt  = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= prdata_nxt;
      pready_r  <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Only the second stage feeds the sequencer; the first may go metastable
  always_comb begin
    comp_s1_nxt = comp_in;
    comp_s2_nxt = comp_s1_r;
  end

  // Comparator passes two flops before use
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      comp_s1_r <= 1'b0;
      comp_s2_r <= 1'b0;
    end else begin
      comp_s1_r <= comp_s1_nxt;
      comp_s2_r <= comp_s2_nxt;
    end
  end

  // Registers and successive-approximation sequencer
  always_comb begin
    power_nxt  = power_r;
    chan_nxt   = chan_r;
    done_nxt   = done_r;
    result_nxt = result_r;
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    sar_nxt    = sar_r;
    bit_nxt    = bit_r;
    afe_nxt    = afe_r;
    // Clear from a result read; a completion below in the same cycle wins
    if (rd_result) begin
      done_nxt = 1'b0;
    end
    unique case (state_r)
      ST_IDLE: begin
        if (power_r) begin
          state_nxt = ST_SAMPLE;
          cnt_nxt   = 6'h00;
        end
      end
      ST_SAMPLE: begin
        cnt_nxt = cnt_r + 6'h01;
        if (cnt_r == SAMPLE_LAST) begin
          state_nxt = ST_RESOLVE;
          sar_nxt   = 8'h80;
          bit_nxt   = 3'h7;
        end
      end
      ST_RESOLVE: begin
        cnt_nxt = cnt_r + 6'h01;
        // The trial leaves on afe_cmd together with sar_r and its answer
        // crosses two synchroniser flops, so deciding in the fourth cycle
        // of a step leaves two cycles of settling for the comparator
        // Decide one bit at the end of each step, MSB first
        if (cnt_r[1:0] == 2'(STEP_CYCLES - 1)) begin
          if (!comp_s2_r) begin
            sar_nxt[bit_r] = 1'b0;
          end
          if (bit_r != 3'h0) begin
            sar_nxt[bit_r - 3'h1] = 1'b1;
            bit_nxt = bit_r - 3'h1;
          end
        end
        if (cnt_r == CNT_LAST) begin
          result_nxt = comp_s2_r ? sar_r : (sar_r & ~8'h01);
          done_nxt   = 1'b1;
          state_nxt  = ST_SAMPLE;
          cnt_nxt    = 6'h00;
        end
      end
    endcase
    // Power off stops everything, result held
    // Power and state change together on a control write, so this mainly
    // guards against a completion ever setting the flag while off
    if (!power_r) begin
      state_nxt = ST_IDLE;
      done_nxt  = rd_result ? 1'b0 : done_r;
      if (state_r == ST_RESOLVE && cnt_r == CNT_LAST) begin
        done_nxt = done_r;
      end
    end
    // Control write aborts, clears done, restarts
    // A write in the cycle a result lands wins: that conversion is aborted
    if (wr_ctrl) begin
      power_nxt  = pwdata[POWER_BIT];
      chan_nxt   = pwdata[CHAN_LSB +: CHAN_W];
      done_nxt   = 1'b0;
      result_nxt = result_r;
      state_nxt  = pwdata[POWER_BIT] ? ST_SAMPLE : ST_IDLE;
      cnt_nxt    = 6'h00;
    end
    afe_nxt.sample  = (state_nxt == ST_SAMPLE);
    afe_nxt.trial   = sar_nxt;
    afe_nxt.channel = chan_decode(chan_nxt);
  end

  // Reset clears everything to zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      power_r  <= CTRL_RESET[POWER_BIT];
      chan_r   <= CTRL_RESET[CHAN_W-1:0];
      done_r   <= CTRL_RESET[DONE_BIT];
      result_r <= RESULT_RESET;
      state_r  <= ST_IDLE;
      cnt_r    <= 6'h00;
      sar_r    <= 8'h00;
      bit_r    <= 3'h0;
      afe_r    <= '0;
    end else begin
      power_r  <= power_nxt;
      chan_r   <= chan_nxt;
      done_r   <= done_nxt;
      result_r <= result_nxt;
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      sar_r    <= sar_nxt;
      bit_r    <= bit_nxt;
      afe_r    <= afe_nxt;
    end
  end

endmodule

// ==== rtl/adc_ctrl_pkg.sv ====
// Contract
// - Done flag bit 7 sets at conversion end; result read or control write clears it.
// - Control bit 5 is read/write power; one switches converter on, zero off.
// - Control bit 4 is reserved and always reads zero regardless of writes.
// - Control bits 2:0 are read/write channel code selecting input 0 to 7.
// - Result register is read-only, 8 bits, latest value; writes are ignored.
// - Reset clears control and result registers to all zeros.
// - Channel count is a parameter of the channel decode.
// - While powered, conversions repeat back to back on the selected channel.
// - Any control write aborts the conversion, clears done, restarts with new settings.
// - Each conversion lasts 64 clocks including a 31.5 clock sampling phase; the sequencer rounds sampling up to 32 clocks.
// - Completion only sets the done flag; no interrupt is raised.
package adc_ctrl_pkg;

  // Register byte addresses
  localparam logic [11:0] RESULT_ADDR  = 12'h1C0;
  localparam logic [11:0] CTRL_ADDR    = 12'h1C4;
  // Printed offsets are not word multiples, so they act as indices
  localparam logic [11:0] RESULT_IDX   = 12'h070;
  localparam logic [11:0] CTRL_IDX     = 12'h071;

  // Control/status field positions
  localparam int DONE_BIT     = 7;
  localparam int POWER_BIT    = 5;
  localparam int CHAN_LSB     = 0;
  localparam int CHAN_W       = 3;

  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;

  // Conversion timing
  localparam int CONV_CYCLES   = 64;
  localparam int SAMPLE_CYCLES = 32;  // 31.5 rounded up to whole clocks
  localparam int RESULT_BITS   = 8;
  localparam int RESOLVE_CYCLES = CONV_CYCLES - SAMPLE_CYCLES;
  localparam int STEP_CYCLES   = RESOLVE_CYCLES / RESULT_BITS;  // 4 per bit
  localparam logic [5:0] CNT_LAST = 6'(CONV_CYCLES - 1);
  localparam logic [5:0] SAMPLE_LAST = 6'(SAMPLE_CYCLES - 1);

  // Stabilisation hint for software, not enforced by hardware
  localparam int    STAB_TIME_NS = 30000;
  localparam int    CLK_PERIOD_NS = 10;
  localparam int    STAB_CYCLES = STAB_TIME_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_RESOLVE} conv_state_t;

  // Analog front-end command; its answer returns on comp_in
  typedef struct packed {
    logic       sample;    // Sample-and-hold tracking
    logic [7:0] trial;     // DAC trial code
    logic [2:0] channel;   // Multiplexer select
  } afe_cmd_t;

endpackage

// ==== verif/adc_regs_monitor.sv ====
`timescale 1ns/1ps
module adc_regs_monitor
  import adc_ctrl_pkg::*;
(
  input wire logic        clk,       // Clock
  input wire logic        resetn,    // Reset, active low
  input wire logic        psel,      // Select
  input wire logic        penable,   // Access phase
  input wire logic        pwrite,    // Direction
  input wire logic [11:0] paddr,     // Byte address
  input wire logic [31:0] pwdata,    // Write data
  input wire logic [31:0] prdata,    // Read data
  input wire logic        pready,    // Ready
  input wire logic        pslverr,   // Error
  input wire logic        comp_in,   // Comparator
  input wire afe_cmd_t    afe_cmd,   // Front-end command
  input wire logic        afe_power  // Bias enable
);
  localparam logic [11:0] CA = {CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] RA = {RESULT_IDX[9:0], 2'b00};
  logic setup;
  logic wr_ctrl;
  // Setup cycle, and a control write at the edge where it takes effect
  assign setup   = psel && !penable;
  assign wr_ctrl = psel && penable && pready && pwrite && paddr == CA;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_ready_next: assert property (setup |=> pready)
    else $error("No ready after setup");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("Ready held too long");
  chk_err_unmapped: assert property (setup && paddr != CA && paddr != RA |=> pslverr)
    else $error("No error on unmapped address");
  chk_ok_mapped: assert property (setup && (paddr == CA || paddr == RA) |=> !pslverr)
    else $error("Error on mapped address");
  chk_byte_wide: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits set");
  chk_rsvd_zero: assert property (pready && !pwrite && paddr == CA |-> !prdata[4])
    else $error("Reserved bit reads one");
  chk_power_bit: assert property (wr_ctrl |-> ##2 afe_power == $past(pwdata[5], 2))
    else $error("Power enable does not follow write");
  chk_chan_mux: assert property (
    wr_ctrl && pwdata[5] |-> ##2 afe_cmd.channel == $past(pwdata[2:0], 2))
    else $error("Channel select does not follow write");
  chk_off_quiet: assert property (!afe_power [*3] |-> !afe_cmd.sample)
    else $error("Sampling while powered off");
endmodule
bind adc_sar_control_regs adc_regs_monitor mon (.*);

// ==== verif/afe_model.sv ====
`timescale 1ns/1ps
module afe_model
  import adc_ctrl_pkg::*;
#(
  parameter logic [63:0] LEVELS = 64'h0  // Input level per channel, channel 0 in low byte
) (
  input  wire logic     clk,      // Clock
  input  wire afe_cmd_t afe_cmd,  // Trial code and channel
  input  wire logic     afe_power, // Bias enable
  output logic          comp_in   // Input above trial
);
  logic       junk_r = 1'b0;
  logic [7:0] level;
  // Unpowered comparator gives no stable answer
  always @(posedge clk) junk_r <= !junk_r;
  // Input sits half a step above its level, so keep-bit means level >= trial
  assign level   = LEVELS[afe_cmd.channel*8 +: 8];
  assign comp_in = afe_power ? (level >= afe_cmd.trial) : junk_r;
endmodule

// ==== verif/adc_sar_control_regs_bench.sv ====
`timescale 1ns/1ps
module adc_sar_control_regs_bench;
  import adc_ctrl_pkg::*;
  localparam logic [63:0] LEVELS = 64'hFF5AA5807F01FE00;
  localparam logic [11:0] CA     = {CTRL_IDX[9:0], 2'b00};
  localparam logic [11:0] RA     = {RESULT_IDX[9:0], 2'b00};
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, comp_in, afe_power, er;
  afe_cmd_t    afe_cmd;
  int          errors = 0, total_checks = 0, cyc = 0, t0;
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  adc_sar_control_regs #(.NUM_CHANNELS(8)) dut (.clk(clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_in(comp_in), .afe_cmd(afe_cmd),
    .afe_power(afe_power));
  afe_model #(.LEVELS(LEVELS)) far (.clk(clk), .afe_cmd(afe_cmd), .afe_power(afe_power),
    .comp_in(comp_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One transfer; waits for ready, the watchdog ends a dead slave's wait
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, CA, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 60);
    chk({31'h0, rd[7]}, 32'h1);
  endtask
  task automatic t_reset();
    apb(1'b0, RA, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, CA, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_power();
    apb(1'b1, CA, 32'h35);
    apb(1'b0, CA, 32'h0);
    chk(rd, 32'h25);
    repeat (STAB_CYCLES) @(posedge clk);
  endtask
  // Abort a conversion on another channel, then time the restarted one
  task automatic t_chans();
    for (int ch = 0; ch < 8; ch++) begin
      apb(1'b1, CA, 32'h20 | (ch ^ 1));
      repeat (40) @(posedge clk);
      apb(1'b1, CA, 32'h20 | ch);
      t0 = cyc;
      wait_done();
      chk({31'h0, (cyc - t0) inside {[60:70]}}, 32'h1);
      apb(1'b0, RA, 32'h0);
      chk(rd, {24'h0, LEVELS[ch*8 +: 8]});
      apb(1'b0, CA, 32'h0);
      chk(rd, 32'h20 | ch);
    end
    repeat (70) @(posedge clk);
    apb(1'b0, CA, 32'h0);
    chk(rd, 32'hA7);
  endtask
  task automatic t_access();
    apb(1'b1, RA, 32'h0);
    apb(1'b0, RA, 32'h0);
    chk(rd, 32'hFF);
    apb(1'b1, 12'h1C8, 32'h25);
    chk({31'h0, er}, 32'h1);
    apb(1'b0, 12'h1C8, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_off();
    apb(1'b1, CA, 32'h02);
    chk({31'h0, afe_power}, 32'h0);
    repeat (150) @(posedge clk);
    apb(1'b0, CA, 32'h0);
    chk(rd, 32'h02);
    apb(1'b0, RA, 32'h0);
    chk(rd, 32'hFF);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Tests need about 4200 cycles; 20000 leaves ample margin
  initial begin
    #200000;
    errors++;
    final_report();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    $display("reset values done");
    t_power();
    $display("power and fields done");
    t_chans();
    $display("channels done");
    t_access();
    $display("access kinds done");
    t_off();
    $display("power off done");
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    $display("second reset done");
    final_report();
  end
endmodule
